//--- fprc_top.sv
// Flash program, status polling, burst ready and hardware reset control
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
module fprc_top #(
    parameter int ARRAY_AW       = 8,
    parameter int PROG_CYCLES    = fprc_pkg::PROG_CYCLES,
    parameter int STANDBY_CYCLES = fprc_pkg::STANDBY_CYCLES
) (
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RESET,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Flash bus pins
    input  wire logic        CS_N,
    input  wire logic        ADDRESS_VALID_STROBE_N,
    input  wire logic        WE_N,
    input  wire logic        OE_N,
    input  wire logic        FCLK,
    input  wire logic        RST_N,
    input  wire logic [20:0] ADDR,
    input  wire logic [15:0] DQ_IN,
    output logic      [15:0] DQ_OUT,
    output logic             DQ_OE,
    output logic             RDY,
    // Interrupt
    output logic             IRQ
);
    localparam int CW        = fprc_pkg::CNT_W;
    localparam int READY_LIM = fprc_pkg::READY_CYCLES;

    ////////////////////////////////////////////////////////////////////////
    fprc_pkg::fprc_ctl_t ctl_m, ctl_s, ctl_p;
    fprc_pkg::fprc_bus_t bus_m, bus_s;

    // Two-stage pin synchronisers; ctl_p only holds the previous settled value
    always_ff @(posedge CLOCK) begin
        ctl_m <= {CS_N, ADDRESS_VALID_STROBE_N, WE_N, OE_N, FCLK, RST_N};
        ctl_s <= ctl_m;
        ctl_p <= ctl_s;
        bus_m <= {ADDR, DQ_IN};
        bus_s <= bus_m;
    end

    // Pin edges seen on the settled copies
    logic sel, rst_low, we_fall, we_rise, oe_fall, avd_rise, avd_fall;
    logic fclk_rise;
    assign sel       = ~ctl_s.cs_n;
    assign rst_low   = ~ctl_s.rst_n;
    assign we_fall   = ctl_p.we_n & ~ctl_s.we_n;
    assign we_rise   = ~ctl_p.we_n & ctl_s.we_n;
    assign oe_fall   = ctl_p.oe_n & ~ctl_s.oe_n;
    assign avd_rise  = ~ctl_p.avd_n & ctl_s.avd_n;
    assign avd_fall  = ctl_p.avd_n & ~ctl_s.avd_n;
    assign fclk_rise = ~ctl_p.fclk & ctl_s.fclk;

    ////////////////////////////////////////////////////////////////////////
    logic [1:0]          cfg, next_cfg;
    logic [20:0]         addr_lat, next_addr_lat, prog_addr, next_prog_addr;
    logic [20:0]         burst_addr, next_burst_addr, rd_addr;
    logic [15:0]         prog_data, next_prog_data, dq_out, next_dq_out;
    logic [15:0]         rd_word, status_word;
    logic [CW-1:0]       busy_cnt, next_busy_cnt, low_cnt, next_low_cnt;
    logic                sync_hold, next_sync_hold, busy, next_busy;
    logic                toggle, next_toggle, standby, next_standby;
    logic                burst_on, next_burst_on, stall_done, next_stall_done;
    logic                rdy_with, next_rdy_with;
    fprc_pkg::fprc_cmd_t cmd, next_cmd;
    logic                sync_evt, wr, beat, stall_now, poll, rd_evt;
    logic                mem_we, ev_done, ev_abort, ev_stby;
    logic [15:0]         mem [2**ARRAY_AW];

    // Event decode shared by the flash state and the assertions
    // first of strobe rise or clock
    assign sync_evt  = sel & ~sync_hold
                     & (avd_rise | (fclk_rise & ~ctl_s.avd_n));
    assign wr        = we_rise & sel & ~busy & ~rst_low;
    assign beat      = burst_on & fclk_rise & sel & ~ctl_s.oe_n;
    assign stall_now = ~stall_done
                     & ((burst_addr[5:0] == fprc_pkg::BOUNDARY_LOW)
                     | (burst_addr == fprc_pkg::ADDR_ZERO));
    assign rd_evt    = (beat & ~stall_now) | (oe_fall & sel & ~burst_on);
    assign rd_addr   = burst_on ? burst_addr : (sync_hold ? addr_lat
                                                          : bus_s.addr);
    assign poll      = busy & (rd_addr[fprc_pkg::BANK_HI:fprc_pkg::BANK_LO]
                     == prog_addr[fprc_pkg::BANK_HI:fprc_pkg::BANK_LO]);
    assign mem_we    = busy & (busy_cnt == CW'(1)) & ~rst_low;

    // Status word seen while the addressed bank is busy
    always_comb begin
        status_word = '0;
        status_word[fprc_pkg::STAT_POLL] = ~prog_data[fprc_pkg::STAT_POLL];
        status_word[fprc_pkg::STAT_TOG1] = toggle;
        status_word[fprc_pkg::STAT_TOG2] = toggle;
        rd_word = poll ? status_word : mem[rd_addr[ARRAY_AW-1:0]];
    end

    // Next state of the flash side
    always_comb begin
        next_addr_lat   = addr_lat;
        next_sync_hold  = sync_hold;
        next_cmd        = cmd;
        next_busy       = busy;
        next_busy_cnt   = busy_cnt;
        next_prog_addr  = prog_addr;
        next_prog_data  = prog_data;
        next_toggle     = toggle;
        next_dq_out     = dq_out;
        next_burst_on   = burst_on;
        next_burst_addr = burst_addr;
        next_stall_done = stall_done;
        next_rdy_with   = rdy_with;
        next_low_cnt    = '0;
        ev_done         = 1'h0;
        ev_abort        = 1'h0;
        // Address capture; a new strobe low frees the latch
        if (avd_fall) begin
            next_sync_hold = 1'h0;
        end else if (sync_evt) begin
            next_sync_hold  = 1'h1;
            next_addr_lat   = bus_s.addr;
            next_burst_on   = cfg[fprc_pkg::CFG_SYNC];
            next_burst_addr = bus_s.addr;
            next_stall_done = 1'h0;
            next_rdy_with   = 1'h0;
        end else if (we_fall & sel & ~sync_hold) begin
            next_addr_lat = bus_s.addr;
        end
        if (~sel | ctl_s.oe_n) begin
            next_burst_on = next_burst_on & sel;
        end
        // Burst beat; a boundary costs one clock with ready low
        if (beat) begin
            next_stall_done = stall_now;
            next_rdy_with   = ~stall_now;
            if (!stall_now) begin
                next_burst_addr = burst_addr + 21'h1;
            end
        end
        if (rd_evt) begin
            next_dq_out = rd_word;
            next_toggle = toggle ^ poll;
        end
        // low 12 address bits decode; no mode check
        unique case (cmd)
            fprc_pkg::CMD_IDLE: begin
                if (wr && addr_lat[11:0] == fprc_pkg::UNLOCK_ADDR1
                    && bus_s.dq[7:0] == fprc_pkg::CMD_UNLOCK1) begin
                    next_cmd = fprc_pkg::CMD_UNL1;
                end
            end
            fprc_pkg::CMD_UNL1: begin
                if (wr) begin
                    next_cmd = (addr_lat[11:0] == fprc_pkg::UNLOCK_ADDR2
                        && bus_s.dq[7:0] == fprc_pkg::CMD_UNLOCK2)
                        ? fprc_pkg::CMD_UNL2 : fprc_pkg::CMD_IDLE;
                end
            end
            fprc_pkg::CMD_UNL2: begin
                if (wr) begin
                    next_cmd = (addr_lat[11:0] == fprc_pkg::UNLOCK_ADDR1
                        && bus_s.dq[7:0] == fprc_pkg::CMD_PROGRAM)
                        ? fprc_pkg::CMD_SETUP : fprc_pkg::CMD_IDLE;
                end
            end
            fprc_pkg::CMD_SETUP: begin
                if (wr) begin
                    next_cmd       = fprc_pkg::CMD_IDLE;
                    next_busy      = 1'h1;
                    next_busy_cnt  = CW'(PROG_CYCLES);
                    next_prog_addr = addr_lat;
                    next_prog_data = bus_s.dq;
                end
            end
        endcase
        // Internal program countdown
        if (busy) begin
            next_busy_cnt = busy_cnt - CW'(1);
            if (busy_cnt == CW'(1)) begin
                next_busy = 1'h0;
                ev_done   = 1'h1;
            end
        end
        // reset pin aborts at once, idle read mode
        if (rst_low) begin
            ev_abort        = busy;
            ev_done         = 1'h0;
            next_busy       = 1'h0;
            next_cmd        = fprc_pkg::CMD_IDLE;
            next_burst_on   = 1'h0;
            next_sync_hold  = 1'h0;
            next_low_cnt    = (low_cnt == '1) ? low_cnt : low_cnt + CW'(1);
        end
        // standby only after the full low time
        next_standby = rst_low & (next_low_cnt >= CW'(STANDBY_CYCLES));
        ev_stby      = next_standby & ~standby;
    end

    // Flash side registers
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            addr_lat   <= '0;
            sync_hold  <= 1'h0;
            cmd        <= fprc_pkg::CMD_IDLE;
            busy       <= 1'h0;
            busy_cnt   <= '0;
            prog_addr  <= '0;
            prog_data  <= '0;
            toggle     <= 1'h0;
            dq_out     <= '0;
            burst_on   <= 1'h0;
            burst_addr <= '0;
            stall_done <= 1'h0;
            rdy_with   <= 1'h0;
            low_cnt    <= '0;
            standby    <= 1'h0;
        end else begin
            addr_lat   <= next_addr_lat;
            sync_hold  <= next_sync_hold;
            cmd        <= next_cmd;
            busy       <= next_busy;
            busy_cnt   <= next_busy_cnt;
            prog_addr  <= next_prog_addr;
            prog_data  <= next_prog_data;
            toggle     <= next_toggle;
            dq_out     <= next_dq_out;
            burst_on   <= next_burst_on;
            burst_addr <= next_burst_addr;
            stall_done <= next_stall_done;
            rdy_with   <= next_rdy_with;
            low_cnt    <= next_low_cnt;
            standby    <= next_standby;
        end
    end

    // Array; programming can only clear bits, as in real cells
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            for (int i = 0; i < 2**ARRAY_AW; i++) begin
                mem[i] <= fprc_pkg::ERASED_WORD;
            end
        end else if (mem_we) begin
            mem[prog_addr[ARRAY_AW-1:0]] <= mem[prog_addr[ARRAY_AW-1:0]]
                                          & prog_data;
        end
    end

    // Pin outputs; ready is early or with data as selected
    assign DQ_OUT = dq_out;
    assign DQ_OE  = sel & ~ctl_s.oe_n & ~rst_low;
    assign RDY    = ~burst_on | (cfg[fprc_pkg::CFG_PHASE] ? rdy_with
                                                          : ~stall_now);

    ////////////////////////////////////////////////////////////////////////
    logic [fprc_pkg::IRQ_W-1:0] irq_st, next_irq_st, irq_en, next_irq_en;
    logic [fprc_pkg::IRQ_W-1:0] irq_set, irq_clr;
    logic [31:0]                prdata, next_prdata;
    logic                       slverr, next_slverr, wr_acc, mapped;

    // APB decode; answers with no wait state, data set up in the setup phase
    always_comb begin
        wr_acc      = PSEL & PENABLE & PWRITE;
        irq_set     = {ev_stby, ev_abort, ev_done};
        irq_clr     = '0;
        next_cfg    = cfg;
        next_irq_en = irq_en;
        next_prdata = prdata;
        next_slverr = slverr;
        mapped      = 1'h1;
        if (wr_acc) begin
            unique case (PADDR)
                fprc_pkg::REG_CONFIG:     next_cfg = PWDATA[1:0];
                fprc_pkg::REG_IRQ_ENABLE:
                    next_irq_en = PWDATA[fprc_pkg::IRQ_W-1:0];
                fprc_pkg::REG_IRQ_CLEAR:
                    irq_clr = PWDATA[fprc_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle
        next_irq_st = (irq_st & ~irq_clr) | irq_set;
        if (PSEL && !PENABLE) begin
            next_prdata = '0;
            unique case (PADDR)
                fprc_pkg::REG_CONFIG:     next_prdata[1:0] = cfg;
                fprc_pkg::REG_STATUS:
                    next_prdata[2:0] = {standby, burst_on, busy};
                fprc_pkg::REG_IRQ_STATUS: next_prdata[2:0] = irq_st;
                fprc_pkg::REG_IRQ_ENABLE: next_prdata[2:0] = irq_en;
                fprc_pkg::REG_IRQ_CLEAR:  ;
                default:                  mapped = 1'h0;
            endcase
            next_slverr = ~mapped;
        end
    end

    // APB and interrupt registers
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            cfg    <= '0;
            irq_en <= '0;
            irq_st <= '0;
            prdata <= '0;
            slverr <= 1'h0;
        end else begin
            cfg    <= next_cfg;
            irq_en <= next_irq_en;
            irq_st <= next_irq_st;
            prdata <= next_prdata;
            slverr <= next_slverr;
        end
    end

    assign PRDATA  = prdata;
    assign PREADY  = 1'h1;
    assign PSLVERR = slverr & PSEL & PENABLE;
    assign IRQ     = |(irq_st & irq_en);

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    sequence s_unlock1;
        wr && cmd == fprc_pkg::CMD_IDLE && !rst_low
        && addr_lat[11:0] == fprc_pkg::UNLOCK_ADDR1
        && bus_s.dq[7:0] == fprc_pkg::CMD_UNLOCK1;
    endsequence
    sequence s_stall;
        beat && stall_now && !rst_low;
    endsequence

    abort_busy_a: assert property (rst_low |=> !busy && !mem_we)
        else $error("program not aborted by reset pin");
    read_mode_a: assert property ($rose(rst_low) |-> ##[1:READY_LIM]
        (cmd == fprc_pkg::CMD_IDLE && !burst_on))
        else $error("reset did not return to read mode");
    standby_late_a: assert property ($rose(standby) |->
        low_cnt == CW'(STANDBY_CYCLES) && $past(rst_low))
        else $error("standby entered too early");
    async_latch_a: assert property (we_fall && sel && !sync_hold
        && !avd_fall && !sync_evt |=> addr_lat == $past(bus_s.addr))
        else $error("async address not latched");
    sync_latch_a: assert property (sync_evt && !avd_fall
        |=> sync_hold && addr_lat == $past(bus_s.addr))
        else $error("sync address not latched");
    unlock_mask_a: assert property (s_unlock1
        |=> cmd == fprc_pkg::CMD_UNL1)
        else $error("unlock cycle not decoded");
    program_start_a: assert property (cmd == fprc_pkg::CMD_SETUP && wr
        && !rst_low |=> busy && prog_addr == $past(addr_lat))
        else $error("program not started");
    poll_invert_a: assert property (rd_evt && poll && !rst_low
        |=> dq_out[fprc_pkg::STAT_POLL] == !prog_data[7])
        else $error("status bit not inverted");
    toggle_step_a: assert property (rd_evt && poll && !rst_low
        |=> toggle != $past(toggle))
        else $error("toggle bit did not change");
    toggle_stop_a: assert property (!busy |=> $stable(toggle))
        else $error("toggle bit moved while idle");
    boundary_stall_a: assert property (s_stall |=> !rdy_with
        && burst_addr == $past(burst_addr) && $stable(dq_out))
        else $error("boundary stall missing");
    ready_early_a: assert property (burst_on && !cfg[fprc_pkg::CFG_PHASE]
        && !RDY |-> stall_now)
        else $error("early ready low without stall");
    bank_read_a: assert property (rd_evt && !poll && !rst_low
        |=> $stable(toggle))
        else $error("array read disturbed status");
endmodule

//--- fprc_pkg.sv
// Shared constants and types for the flash program and reset controller
package fprc_pkg;
    // Clock and reset pin timing
    localparam int CLK_NS         = 4;
    localparam int T_READYW_NS    = 35000;
    localparam int T_READY_NS     = 500;
    localparam int T_STANDBY_NS   = 20000;
    localparam int READYW_CYCLES  = T_READYW_NS / CLK_NS;
    localparam int READY_CYCLES   = T_READY_NS / CLK_NS;
    localparam int STANDBY_CYCLES = (T_STANDBY_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROG_CYCLES    = 64;
    localparam int CNT_W          = 16;
    // Command decode, low address bits only
    localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
    localparam logic [11:0] UNLOCK_ADDR2 = 12'h2AA;
    localparam logic [7:0]  CMD_UNLOCK1  = 8'hAA;
    localparam logic [7:0]  CMD_UNLOCK2  = 8'h55;
    localparam logic [7:0]  CMD_PROGRAM  = 8'hA0;
    localparam logic [15:0] ERASED_WORD  = 16'hFFFF;
    // Address layout
    localparam int          BANK_HI      = 20;
    localparam int          BANK_LO      = 19;
    localparam logic [5:0]  BOUNDARY_LOW = 6'h3F;
    localparam logic [20:0] ADDR_ZERO    = 21'h000000;
    // Status word bits
    localparam int STAT_POLL = 7;
    localparam int STAT_TOG1 = 6;
    localparam int STAT_TOG2 = 2;
    // APB register byte offsets
    localparam logic [7:0] REG_CONFIG     = 8'h00;
    localparam logic [7:0] REG_STATUS     = 8'h04;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_ENABLE = 8'h0C;
    localparam logic [7:0] REG_IRQ_CLEAR  = 8'h10;
    // Field positions
    localparam int CFG_PHASE = 0;
    localparam int CFG_SYNC  = 1;
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_ABORT = 1;
    localparam int IRQ_STBY  = 2;
    localparam int IRQ_W     = 3;
    // Command sequence states
    typedef enum logic [1:0] {
        CMD_IDLE, CMD_UNL1, CMD_UNL2, CMD_SETUP
    } fprc_cmd_t;
    // Flash control pins and bus as they travel through the synchroniser
    typedef struct packed {
        logic cs_n;
        logic avd_n;
        logic we_n;
        logic oe_n;
        logic fclk;
        logic rst_n;
    } fprc_ctl_t;
    typedef struct packed {
        logic [20:0] addr;
        logic [15:0] dq;
    } fprc_bus_t;
endpackage

//--- fprc_host.sv
// Host side model that drives the flash bus pins
`timescale 1ns/1ps
module fprc_host (
    // Clock
    input  wire logic        clock,
    // Flash pins driven by the host
    output logic             cs_n,
    output logic             avs_n,
    output logic             we_n,
    output logic             oe_n,
    output logic             fclk,
    output logic             rst_n,
    output logic      [20:0] addr,
    output logic      [15:0] dq,
    // Flash pins seen by the host
    input  wire logic [15:0] dq_out,
    input  wire logic        rdy
);
    // Idle bus: deselected, strobes high, flash clock parked low
    initial begin
        {cs_n, avs_n, we_n, oe_n, rst_n} = 5'h1F;
        fclk = 1'b0;
        addr = 21'h000000;
        dq   = 16'h0000;
    end

    ////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask

    // One write; address moves early to catch a late latch
    // rel high ends the write deselected, low keeps chip select down
    task automatic wr(input logic [20:0] a, input logic [15:0] d,
                      input logic sy, input logic rel = 1'b1);
        addr  <= a;
        dq    <= d;
        cs_n  <= 1'b0;
        avs_n <= 1'b0;
        step(5);
        if (sy) begin
            avs_n <= 1'b1;
            step(5);
            addr <= ~a;
        end
        we_n <= 1'b0;
        step(5);
        addr <= ~a;
        step(5);
        we_n <= 1'b1;
        step(5);
        dq    <= ~d; // Released bus never shows the last word
        // chip select or strobe rises between cycles
        avs_n <= ~rel;
        cs_n  <= rel;
        step(3);
    endtask

    task automatic rd(input logic [20:0] a, output logic [15:0] d);
        addr  <= a;
        cs_n  <= 1'b0;
        avs_n <= 1'b0;
        step(5);
        avs_n <= 1'b1;
        step(5);
        oe_n <= 1'b0;
        step(7);
        d = dq_out;
        oe_n <= 1'b1;
        cs_n <= 1'b1;
        step(3);
    endtask

    // Burst of n beats; counts clocks with ready low
    task automatic burst(input logic [20:0] a, input int n, output int c);
        c = 0;
        addr  <= a;
        cs_n  <= 1'b0;
        avs_n <= 1'b0;
        step(5);
        avs_n <= 1'b1;
        oe_n  <= 1'b0;
        step(5);
        for (int i = 0; i < 8 * n; i++) begin
            fclk <= i[2];
            @(posedge clock);
            if (rdy !== 1'b1) c++;
        end
        fclk <= 1'b0;
        oe_n <= 1'b1;
        cs_n <= 1'b1;
        step(3);
    endtask

    task automatic pinrst(input int n);
        rst_n <= 1'b0;
        step(n);
        rst_n <= 1'b1;
    endtask
endmodule

//--- fprc_top_test.sv
// Self-checking bench for the flash program and reset controller
`timescale 1ns/1ps
module fprc_top_test;
    logic        clock, reset, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, s, got_d, r;
    logic        cs_n, avs_n, we_n, oe_n, fclk, rst_n, dq_oe, rdy, irq;
    logic [20:0] addr;
    logic [15:0] dq, dq_out;
    logic        got_v, serr;
    logic [31:0] q[$];
    int          fail_count, num_checks, cyc;

    // Standby count shortened so the run stays brief; program count left at 64
    fprc_top #(.PROG_CYCLES(64), .STANDBY_CYCLES(20)) DUT (
        .CLOCK(clock), .RESET(reset), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CS_N(cs_n), .ADDRESS_VALID_STROBE_N(avs_n), .WE_N(we_n),
        .OE_N(oe_n), .FCLK(fclk), .RST_N(rst_n), .ADDR(addr),
        .DQ_IN(dq), .DQ_OUT(dq_out), .DQ_OE(dq_oe), .RDY(rdy), .IRQ(irq));
    fprc_host u_host (
        .clock(clock), .cs_n(cs_n), .avs_n(avs_n), .we_n(we_n),
        .oe_n(oe_n), .fclk(fclk), .rst_n(rst_n), .addr(addr), .dq(dq),
        .dq_out(dq_out), .rdy(rdy));

    // Clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    ////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    // APB transfer; no fixed latency assumed, only the hang guard ends a
    // stall; hold keeps psel up for a setup cycle that follows at once
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic hold = 1'b0);
        if (psel !== 1'b1) begin
            psel <= 1'b1;
        end
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        r = prdata;
        serr = pslverr;
        psel    <= hold;
        penable <= 1'b0;
        if (!hold) begin
            @(posedge clock);
        end
    endtask

    // Note the expectation, then hand the result to the watcher
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        q.push_back(e);
        got_d <= g;
        got_v <= 1'b1;
        @(posedge clock);
        got_v <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rr(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(e, r);
    endtask

    // Command sequence with random don't-care upper bits
    task automatic prog(input logic [20:0] a, input logic [15:0] d,
                        input logic sy);
        logic [31:0] x;
        x = rnd();
        u_host.wr({x[8:0], fprc_pkg::UNLOCK_ADDR1},
                  {8'h00, fprc_pkg::CMD_UNLOCK1}, sy, x[27]);
        u_host.wr({x[17:9], fprc_pkg::UNLOCK_ADDR2},
                  {8'h00, fprc_pkg::CMD_UNLOCK2}, sy, x[28]);
        u_host.wr({x[26:18], fprc_pkg::UNLOCK_ADDR1},
                  {8'h00, fprc_pkg::CMD_PROGRAM}, sy, x[29]);
        u_host.wr(a, d, sy, 1'b1);
    endtask

    // Oldest note against each result seen
    always @(posedge clock) begin
        if (got_v) begin
            num_checks++;
            if (q.pop_front() !== got_d) begin
                fail_count++;
                $display("CHECK FAILED %0t got %h", $time, got_d);
            end
        end
    end

    // Hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////
    initial begin
        logic [31:0] x;
        logic [15:0] d, d2, r1, r2, r3;
        int          na, nb, nz;
        s = 32'hBEE7831A;
        {reset, psel, penable, pwrite, got_v} = 5'h10;
        paddr  = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        rr(fprc_pkg::REG_CONFIG, 32'h0);
        rr(fprc_pkg::REG_STATUS, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk(32'h1, {31'h0, serr});
        // Async program, then poll while busy
        apb(1'b1, fprc_pkg::REG_IRQ_ENABLE, 32'h7);
        x = rnd();
        d = x[15:0];
        prog(21'h080042, d, 1'b0);
        u_host.rd(21'h080042, r1);
        u_host.rd(21'h080042, r2);
        fork
            u_host.rd(21'h100011, r3);
            begin
                u_host.step(15);
                chk(32'h1, {31'h0, dq_oe});
            end
        join
        chk({30'h0, ~d[7], ~d[7]}, {30'h0, r1[7], r2[7]});
        chk(32'h44, {16'h0, (r1 ^ r2) & 16'h0044});
        chk(32'hFFFF, {16'h0, r3});
        u_host.step(80);
        u_host.rd(21'h080042, r1);
        u_host.rd(21'h080042, r2);
        chk({d, d}, {r1, r2});
        rr(fprc_pkg::REG_IRQ_STATUS, 32'h1);
        chk(32'h1, {31'h0, irq});
        apb(1'b1, fprc_pkg::REG_IRQ_CLEAR, 32'h7);
        chk(32'h0, {31'h0, irq});
        // Sync program with burst read mode selected
        apb(1'b1, fprc_pkg::REG_CONFIG, 32'h3);
        d2 = x[31:16];
        prog(21'h0000A5, d2, 1'b1);
        u_host.step(80);
        apb(1'b1, fprc_pkg::REG_CONFIG, 32'h0, 1'b1);
        apb(1'b1, fprc_pkg::REG_IRQ_CLEAR, 32'h7, 1'b1);
        apb(1'b1, fprc_pkg::REG_IRQ_ENABLE, 32'h0);
        // Reset pin during a running program; interrupt masked
        prog(21'h000033, d, 1'b0);
        fork
            u_host.pinrst(140);
            begin
                u_host.step(10);
                rr(fprc_pkg::REG_STATUS, 32'h0);
                u_host.step(30);
                rr(fprc_pkg::REG_STATUS, 32'h4);
                rr(fprc_pkg::REG_IRQ_STATUS, 32'h6);
                chk(32'h0, {31'h0, irq});
                chk(32'h0, {31'h0, dq_oe});
            end
        join
        u_host.step(50);
        u_host.rd(21'h0000A5, r1);
        chk({16'h0, d2}, {16'h0, r1});
        // Aborted program must leave its word erased
        u_host.rd(21'h000033, r2);
        chk(32'hFFFF, {16'h0, r2});
        // Bursts across boundaries in both ready phasings
        for (int ph = 0; ph < 2; ph++) begin
            apb(1'b1, fprc_pkg::REG_CONFIG, 32'(2 + ph));
            u_host.burst(21'h000010, 4, na);
            u_host.burst(21'h00003E, 4, nb);
            u_host.burst(21'h000000, 4, nz);
            chk(32'h3, {30'h0, nb > na, nz > na});
        end
        finish_test();
    end
endmodule
